// *** gsm_pkg.sv ***
package gsm_pkg;

  // slot geometry
  localparam int          NUM_SLOTS       = 16;
  localparam int          MEM_BYTES       = 320;
  localparam int          SHORT_SLOT      = 6;
  localparam int          LONG_SLOT       = 20;
  localparam int          ADDR_W          = 9;

  // byte offsets inside a slot
  localparam int          OFS_CMD         = 0;
  localparam int          OFS_FAULT       = 1;
  localparam int          OFS_WCOUNT      = 1;
  localparam int          OFS_ORIGIN      = 2;
  localparam int          OFS_WEIGHT      = 2;
  localparam int          OFS_WVALS       = 4;
  localparam int          OFS_DECIMALS    = 6;
  localparam int          OFS_STATE_A     = 8;
  localparam int          OFS_STATE_B     = 10;
  localparam int          OFS_STATE_B_LO  = 11;
  localparam int          OFS_WIN_ORIGIN  = 12;
  localparam int          OFS_WIN_WORD0   = 14;

  // field positions
  localparam int          ST_PWRFAIL_BIT  = 5;
  localparam int          STB_PWRFAIL_BIT = 4;

  // command and answer codes
  localparam logic [7:0]  CMD_NONE        = 8'h00;
  localparam logic [7:0]  CMD_WRITE       = 8'hC8;
  localparam logic [7:0]  CMD_WINDOW      = 8'hC9;
  localparam logic [7:0]  CMD_PFCLR       = 8'hCA;
  localparam logic [7:0]  ACK_REFUSED     = 8'hFA;
  localparam logic [7:0]  FAULT_COMM      = 8'hFF;
  localparam logic [7:0]  CODE_OK         = 8'h00;
  localparam logic [7:0]  MAX_WRITE_WORDS = 8'h08;

  // integer weight limits
  localparam logic signed [31:0] INT_MAX  = 32'sh00007FFF;
  localparam logic signed [31:0] INT_MIN  = -32'sh00008000;

  // reset values
  localparam logic [7:0]  RST_BYTE        = 8'h00;

  typedef enum {GSM_IDLE, GSM_WAIT} gsm_state_t;

endpackage

// *** gsm_slot_memory.sv ***
// Summary of operation
// - multi-byte values stored most significant byte first
// - short layout: six-byte slot per slave
// - short inbound byte 0 is status bits
// - unsupported status functions read zero, except bit 5
// - short status bit 5 sticky until 202
// - commands fire only when command byte changes
// - fault byte reads 255 on link failure
// - short integer weight: integer word, milli word
// - integer word saturates to signed sixteen bits
// - float format: IEEE single, MSB first
// - long layout: twenty-byte slot per slave
// - long integer: 32-bit weight, decimals bytes 6-7
// - long float: significant decimals in bytes 6-7
// - command 200 writes up to eight registers
// - command 201 sets three-register read window
// - long status word two bit 4 sticky
// - long byte 0 acknowledges command or error
// - only process parameters reachable, no set-up
// - one setting selects short or long layout
module gsm_slot_memory
  import gsm_pkg::*;
(
  // clock and reset
  input  wire logic          CLK_SYS,
  input  wire logic          RESETN,
  // configuration
  input  wire logic          SLOT_SIZE_SETTING,
  input  wire logic          WEIGHT_FORMAT_FLOAT,
  // fieldbus side of the shared memory
  input  wire logic [8:0]    FB_ADDR,
  input  wire logic          FB_WE,
  input  wire logic [7:0]    FB_WDATA,
  output logic      [7:0]    FB_RDATA,
  // slave data from the polling engine
  input  wire logic          UPD_VALID,
  input  wire logic [3:0]    UPD_SLOT,
  input  wire logic          UPD_COMM_OK,
  input  wire logic [7:0]    UPD_FAULT,
  input  wire logic [7:0]    UPD_STATUS,
  input  wire logic [7:0]    UPD_SUPPORT,
  input  wire logic          UPD_PWRFAIL,
  input  wire logic [31:0]   UPD_INT_PART,
  input  wire logic [15:0]   UPD_FRAC_MILLI,
  input  wire logic [31:0]   UPD_FLOAT,
  input  wire logic [31:0]   UPD_SCALED,
  input  wire logic [15:0]   UPD_DECIMALS,
  input  wire logic [15:0]   UPD_STATE_A,
  input  wire logic [15:0]   UPD_STATE_B,
  input  wire logic [47:0]   UPD_WIN_WORDS,
  // requests to the polling engine
  output logic               REQ_VALID,
  output logic      [3:0]    REQ_SLOT,
  output logic      [7:0]    REQ_CMD,
  output logic      [7:0]    REQ_COUNT,
  output logic      [15:0]   REQ_ORIGIN,
  output logic      [127:0]  REQ_WORDS,
  input  wire logic          REQ_DONE,
  input  wire logic [7:0]    REQ_CODE
);

  logic [7:0]   out_mem [MEM_BYTES];
  logic [7:0]   in_mem  [MEM_BYTES];
  logic [7:0]   last_cmd_r [NUM_SLOTS];
  logic [15:0]  pf_r;
  logic [3:0]   scan_r;
  gsm_state_t   state_r;
  logic [7:0]   rdata_nxt;
  logic [159:0] upd_img;
  logic [8:0]   scan_base;
  logic [8:0]   upd_base;
  logic [7:0]   scan_cmd;
  logic [7:0]   scan_cnt;
  logic [8:0]   slot_bytes;

  // memory organisation
  // the shared map is two byte arrays of equal size
  // out_mem holds what the fieldbus master writes
  // in_mem holds what the polling engine reports
  // both arrays are indexed by the same byte address
  // a fieldbus read always returns the inbound side
  // a fieldbus write always lands on the outbound side
  // so one address carries two meanings, one per direction
  // sixteen slots exist in either slot layout
  // short layout uses bytes 0 to 95 of each array
  // long layout uses bytes 0 to 319 of each array
  // bytes beyond the active layout read as zero
  // writes beyond the active layout are dropped
  //
  // slot addressing
  // slot index s maps to slave s plus one
  // short slot base is six times the index
  // long slot base is twenty times the index
  // the layout input picks the multiplier for all slots
  // changing the layout at run time is not guarded
  // a layout change should be followed by a reset
  //
  // byte order
  // every multi-byte field is stored high byte first
  // the master must swap bytes if it works the other way
  // no swapping logic exists anywhere in this block
  //
  // short inbound slot
  // byte 0 is the status byte of the slave
  // unsupported status bits are masked to zero
  // bit 5 comes from the sticky power-fail flag
  // byte 1 is the slave fault code, or all ones on link loss
  // bytes 2 to 5 hold the weight
  // integer format: clamped integer word, then milli word
  // float format: single precision value, high byte first
  //
  // long inbound slot
  // byte 0 is the command reply, written by this block
  // byte 1 is the slave fault code, or all ones on link loss
  // bytes 2 to 5 hold the weight, integer or float
  // bytes 6 and 7 hold the decimal places
  // bytes 8 to 11 hold the two slave state words
  // bit 4 of the second state word is the sticky flag
  // bytes 12 and 13 hold the accepted window origin
  // bytes 14 to 19 hold the three window words
  //
  // long outbound slot
  // byte 0 is the command byte
  // byte 1 is the number of words to write
  // bytes 2 and 3 are the start address
  // bytes 4 to 19 are up to eight words to write
  //
  // command handling
  // a scanner visits one slot per idle cycle
  // a command byte that differs from the stored copy fires
  // the copy is updated at once, so a value fires once
  // a change to zero is remembered but raises no request
  // to repeat a command the master writes zero first
  // the master should write the command byte last
  // otherwise the request may carry stale argument bytes
  // a long write with a bad count is answered at once
  // only one request is outstanding at any time
  // the scanner halts while a request is pending
  // on completion the reply byte takes the command or code
  //
  // power-fail flags
  // one flag per slot, set by a slave report
  // cleared only by a completed clear command
  // a report in the same cycle as the clear wins
  //
  // limitations
  // set-up parameters are not reachable through the map
  // the polling engine is trusted to reject them
  // the short layout has no reply byte
  // no long counts are kept for any slave

  // byte address of a slot's first byte
  function automatic logic [8:0] slot_base(input logic lng, input logic [3:0] s);
    slot_base = lng ? 9'(s * LONG_SLOT) : 9'(s * SHORT_SLOT);
  endfunction

  // clamp a 32-bit integer part into a signed word
  // values above the top clamp to the largest word
  // values below the bottom clamp to the smallest word
  function automatic logic [15:0] sat16(input logic signed [31:0] v);
    if (v > INT_MAX) begin
      sat16 = 16'h7FFF;
    end else if (v < INT_MIN) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  assign slot_bytes = SLOT_SIZE_SETTING ? 9'(LONG_SLOT) : 9'(SHORT_SLOT);
  assign scan_base  = slot_base(SLOT_SIZE_SETTING, scan_r);
  assign upd_base   = slot_base(SLOT_SIZE_SETTING, UPD_SLOT);
  assign scan_cmd   = out_mem[scan_base];
  assign scan_cnt   = out_mem[scan_base + 9'(OFS_WCOUNT)];

  // big-endian image of one slot's inbound data
  // bit 159 is the top bit of slot byte 0
  // the short power-fail bit is left clear here, long state bit 4 passes raw
  // it is merged from the flag when the byte is read
  always_comb begin
    logic [31:0] wgt;
    logic [7:0]  fault;
    logic [7:0]  stat;
    wgt   = 32'h0000_0000;
    fault = UPD_COMM_OK ? UPD_FAULT : FAULT_COMM;
    stat  = UPD_STATUS & UPD_SUPPORT;
    stat[ST_PWRFAIL_BIT] = 1'b0;
    if (WEIGHT_FORMAT_FLOAT) begin
      wgt = UPD_FLOAT;
    end else if (SLOT_SIZE_SETTING) begin
      wgt = UPD_SCALED;
    end else begin
      wgt = {sat16(UPD_INT_PART), UPD_FRAC_MILLI};
    end
    if (SLOT_SIZE_SETTING) begin
      // decimals field serves both formats
      upd_img = {RST_BYTE, fault, wgt, UPD_DECIMALS, UPD_STATE_A, UPD_STATE_B,
                 16'h0000, UPD_WIN_WORDS};
    end else begin
      upd_img = {stat, fault, wgt, 112'h0};
    end
  end

  // fieldbus writes into the outbound area
  // out-of-map writes are dropped, not wrapped
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        out_mem[i] <= RST_BYTE;
      end
    end else if (FB_WE && (FB_ADDR < 9'(NUM_SLOTS) * slot_bytes)) begin
      out_mem[FB_ADDR] <= FB_WDATA;
    end
  end

  // fieldbus read of the inbound area, sticky bits merged in
  // s is the slot index, k the byte within the slot
  // out-of-map reads return zero
  always_comb begin
    logic [3:0] s;
    logic [4:0] k;
    s = 4'(FB_ADDR / slot_bytes);
    k = 5'(FB_ADDR % slot_bytes);
    rdata_nxt = RST_BYTE;
    if (FB_ADDR < 9'(NUM_SLOTS) * slot_bytes) begin
      rdata_nxt = in_mem[FB_ADDR];
      if (!SLOT_SIZE_SETTING && k == 5'(OFS_CMD)) begin
        rdata_nxt[ST_PWRFAIL_BIT] = pf_r[s];
      end
      if (SLOT_SIZE_SETTING && k == 5'(OFS_STATE_B_LO)) begin
        rdata_nxt[STB_PWRFAIL_BIT] = pf_r[s];
      end
    end
  end

  // registered read data
  // data appears one cycle after the address
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      FB_RDATA <= RST_BYTE;
    end else begin
      FB_RDATA <= rdata_nxt;
    end
  end

  // power-fail flags: set wins over the clear command
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      pf_r <= 16'h0000;
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        if (UPD_VALID && UPD_COMM_OK && UPD_PWRFAIL && UPD_SLOT == 4'(i)) begin
          pf_r[i] <= 1'b1;
        end else if (state_r == GSM_WAIT && REQ_DONE && REQ_CODE == CODE_OK &&
                     REQ_CMD == CMD_PFCLR && REQ_SLOT == 4'(i)) begin
          pf_r[i] <= 1'b0;
        end
      end
    end
  end

  // inbound memory: slave data and command answers
  // a failed link only rewrites the fault byte
  // long reply byte and window origin belong to this block
  // bad write counts are answered without a request
  // completions write the reply and, for a window, its origin
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        in_mem[i] <= RST_BYTE;
      end
    end else begin
      if (UPD_VALID) begin
        for (int k = 0; k < LONG_SLOT; k++) begin
          if (9'(k) < slot_bytes && (UPD_COMM_OK || k == OFS_FAULT) &&
              !(SLOT_SIZE_SETTING && (k == OFS_CMD || k == OFS_WIN_ORIGIN ||
                                      k == OFS_WIN_ORIGIN + 1))) begin
            in_mem[upd_base + 9'(k)] <= upd_img[159 - 8 * k -: 8];
          end
        end
      end
      if (state_r == GSM_IDLE && scan_cmd != last_cmd_r[scan_r] && scan_cmd == CMD_WRITE &&
          SLOT_SIZE_SETTING && (scan_cnt == 8'h00 || scan_cnt > MAX_WRITE_WORDS)) begin
        in_mem[scan_base] <= ACK_REFUSED;
      end
      if (state_r == GSM_WAIT && REQ_DONE && SLOT_SIZE_SETTING) begin
        in_mem[slot_base(1'b1, REQ_SLOT)] <= (REQ_CODE == CODE_OK) ? REQ_CMD : REQ_CODE;
        if (REQ_CODE == CODE_OK && REQ_CMD == CMD_WINDOW) begin
          in_mem[slot_base(1'b1, REQ_SLOT) + 9'(OFS_WIN_ORIGIN)]     <= REQ_ORIGIN[15:8];
          in_mem[slot_base(1'b1, REQ_SLOT) + 9'(OFS_WIN_ORIGIN + 1)] <= REQ_ORIGIN[7:0];
        end
      end
    end
  end

  // remembered command byte per slot
  // updated on every change, zero included
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        last_cmd_r[i] <= CMD_NONE;
      end
    end else if (state_r == GSM_IDLE && scan_cmd != last_cmd_r[scan_r]) begin
      last_cmd_r[scan_r] <= scan_cmd;
    end
  end

  // scan slots, forward changed commands, wait for completion
  // request fields are frozen while the request is pending
  // the scanner moves on to the next slot after completion
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      state_r    <= GSM_IDLE;
      scan_r     <= 4'h0;
      REQ_VALID  <= 1'b0;
      REQ_SLOT   <= 4'h0;
      REQ_CMD    <= CMD_NONE;
      REQ_COUNT  <= 8'h00;
      REQ_ORIGIN <= 16'h0000;
      REQ_WORDS  <= 128'h0;
    end else begin
      case (state_r)
        GSM_IDLE: begin
          scan_r <= scan_r + 4'h1;
          if (scan_cmd != last_cmd_r[scan_r] && scan_cmd != CMD_NONE &&
              !(SLOT_SIZE_SETTING && scan_cmd == CMD_WRITE &&
                (scan_cnt == 8'h00 || scan_cnt > MAX_WRITE_WORDS))) begin
            state_r    <= GSM_WAIT;
            scan_r     <= scan_r;
            REQ_VALID  <= 1'b1;
            REQ_SLOT   <= scan_r;
            REQ_CMD    <= scan_cmd;
            REQ_COUNT  <= SLOT_SIZE_SETTING ? scan_cnt : 8'h00;
            REQ_ORIGIN <= SLOT_SIZE_SETTING ?
                          {out_mem[scan_base + 9'(OFS_ORIGIN)],
                           out_mem[scan_base + 9'(OFS_ORIGIN + 1)]} : 16'h0000;
            for (int i = 0; i < 16; i++) begin
              REQ_WORDS[127 - 8 * i -: 8] <= SLOT_SIZE_SETTING ?
                                             out_mem[scan_base + 9'(OFS_WVALS + i)] :
                                             RST_BYTE;
            end
          end
        end
        GSM_WAIT: begin
          if (REQ_DONE) begin
            state_r   <= GSM_IDLE;
            scan_r    <= scan_r + 4'h1;
            REQ_VALID <= 1'b0;
          end
        end
        default: begin
          state_r   <= GSM_IDLE;
          REQ_VALID <= 1'b0;
        end
      endcase
    end
  end

endmodule // gsm_slot_memory

// *** gsm_slot_memory_monitor.sv ***
module gsm_slot_memory_monitor
  import gsm_pkg::*;
(
  // watched ports
  input wire logic          CLK_SYS,
  input wire logic          RESETN,
  input wire logic          SLOT_SIZE_SETTING,
  input wire logic [8:0]    FB_ADDR,
  input wire logic [7:0]    FB_RDATA,
  input wire logic          REQ_VALID,
  input wire logic [3:0]    REQ_SLOT,
  input wire logic [7:0]    REQ_CMD,
  input wire logic [7:0]    REQ_COUNT,
  input wire logic [15:0]   REQ_ORIGIN,
  input wire logic          REQ_DONE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // request phases
  sequence s_wait; REQ_VALID && !REQ_DONE; endsequence
  sequence s_done; REQ_VALID && REQ_DONE; endsequence
  a_req_held: assert property (s_wait |=> REQ_VALID && $stable({REQ_SLOT, REQ_CMD}))
    else $error("request changed while pending");
  a_req_drop: assert property (s_done |=> !REQ_VALID)
    else $error("request held after done");
  a_drop_cause: assert property ($fell(REQ_VALID) && $past(RESETN) |-> $past(REQ_DONE))
    else $error("request dropped without done");
  a_nonzero_cmd: assert property ($rose(REQ_VALID) |-> REQ_CMD != CMD_NONE)
    else $error("request for empty command");
  a_write_count: assert property (REQ_VALID && SLOT_SIZE_SETTING && REQ_CMD == CMD_WRITE
    |-> REQ_COUNT inside {[1:8]})
    else $error("write count out of range");
  a_short_bare: assert property (REQ_VALID && !SLOT_SIZE_SETTING |-> REQ_COUNT == 8'h00
    && REQ_ORIGIN == 16'h0000)
    else $error("short request carries arguments");
  a_oob_zero: assert property (FB_ADDR >= (SLOT_SIZE_SETTING ? 9'h140 : 9'h060)
    |=> FB_RDATA == 8'h00)
    else $error("read beyond map not zero");
  a_reset_clear: assert property (disable iff (1'b0) !RESETN |=> FB_RDATA == 8'h00
    && !REQ_VALID)
    else $error("reset left outputs set");
endmodule // gsm_slot_memory_monitor

bind gsm_slot_memory gsm_slot_memory_monitor mon_u (.*);

// *** gsm_engine_model.sv ***
module gsm_engine_model
  import gsm_pkg::*;
#(
  parameter int DLY = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // request side
  input  wire logic         req_valid,
  input  wire logic [3:0]   req_slot,
  input  wire logic [7:0]   req_count,
  input  wire logic [127:0] req_words,
  input  wire logic [7:0]   req_cmd,
  input  wire logic [15:0]  req_origin,
  input  wire logic [7:0]   code_set,
  output logic              req_done,
  output logic      [7:0]   req_code,
  // what was served
  output logic      [7:0]   last_cmd,
  output logic      [15:0]  last_origin,
  output logic      [3:0]   last_slot,
  output logic      [7:0]   last_count,
  output logic      [127:0] last_words,
  output int                n_done
);
  int cnt;
  // answer each pending request once, after a delay
  always @(posedge clk) begin
    req_done <= 1'b0;
    req_code <= ~code_set;
    if (!rstn) begin
      n_done <= 0;
      cnt <= 0;
    end else if (req_valid && !req_done) begin
      if (cnt == DLY) begin
        req_done <= 1'b1;
        req_code <= code_set;
        last_cmd <= req_cmd;
        last_origin <= req_origin;
        last_slot <= req_slot;
        last_count <= req_count;
        last_words <= req_words;
        n_done <= n_done + 1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // gsm_engine_model

// *** gateway_slot_memory_tb.sv ***
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module gateway_slot_memory_tb
  import gsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS, RESETN, SLOT_SIZE_SETTING, WEIGHT_FORMAT_FLOAT, FB_WE, UPD_VALID;
  logic UPD_COMM_OK, UPD_PWRFAIL, REQ_VALID, REQ_DONE;
  logic [8:0] FB_ADDR;
  logic [3:0] UPD_SLOT, REQ_SLOT;
  logic [7:0] FB_WDATA, FB_RDATA, UPD_FAULT, UPD_STATUS, UPD_SUPPORT, REQ_CMD;
  logic [7:0] REQ_COUNT, REQ_CODE, code_set, last_cmd;
  logic [15:0] UPD_FRAC_MILLI, UPD_DECIMALS, UPD_STATE_A, UPD_STATE_B;
  logic [15:0] REQ_ORIGIN, last_origin;
  logic [31:0] UPD_INT_PART, UPD_FLOAT, UPD_SCALED;
  logic [47:0] UPD_WIN_WORDS;
  logic [127:0] REQ_WORDS, last_words;
  logic [3:0] last_slot;
  logic [7:0] last_count;
  int fails, num_checks, n_done, base;
  // design and polling engine
  gsm_slot_memory dut_u (.*);
  gsm_engine_model #(.DLY(3)) eng_u (.clk(CLK_SYS), .rstn(RESETN), .req_valid(REQ_VALID),
    .req_slot(REQ_SLOT), .req_count(REQ_COUNT), .req_words(REQ_WORDS),
    .req_cmd(REQ_CMD), .req_origin(REQ_ORIGIN), .code_set(code_set), .req_done(REQ_DONE),
    .req_code(REQ_CODE), .last_cmd(last_cmd), .last_origin(last_origin),
    .last_slot(last_slot), .last_count(last_count), .last_words(last_words), .n_done(n_done));
  // 10 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rst(input logic sz);
    @(posedge CLK_SYS);
    RESETN <= 1'b0;
    SLOT_SIZE_SETTING <= sz;
    repeat (2) @(posedge CLK_SYS);
    RESETN <= 1'b1;
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    @(posedge CLK_SYS);
    FB_ADDR <= a[8:0];
    FB_WE <= 1'b1;
    FB_WDATA <= d;
    @(posedge CLK_SYS);
    FB_WE <= 1'b0;
  endtask
  // read n bytes, most significant first
  task automatic rd(input int a, input int n, input logic [31:0] e);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK_SYS);
      FB_ADDR <= 9'(a + i);
      @(posedge CLK_SYS);
      #1 `CHK(FB_RDATA, e[8*(n-1-i) +: 8])
    end
  endtask
  task automatic upd(input int s, input logic ok, input logic pf);
    @(posedge CLK_SYS);
    UPD_VALID <= 1'b1;
    UPD_SLOT <= s[3:0];
    UPD_COMM_OK <= ok;
    UPD_PWRFAIL <= pf;
    @(posedge CLK_SYS);
    UPD_VALID <= 1'b0;
  endtask
  // command byte written last, then count served requests
  task automatic cmd(input logic [7:0] c, input int exp_n);
    wr(base, c);
    repeat (60) @(posedge CLK_SYS);
    `CHK(n_done, exp_n)
  endtask
  // hang guard
  initial begin
    #5000000;
    fails++;
    wrap_up();
  end
  // main sequence
  initial begin
    {RESETN, FB_WE, UPD_VALID, UPD_COMM_OK, UPD_PWRFAIL, WEIGHT_FORMAT_FLOAT} = '0;
    {FB_ADDR, FB_WDATA, UPD_SLOT, code_set, UPD_STATE_B} = '0;
    SLOT_SIZE_SETTING = 1'b1;
    UPD_FAULT = 8'h07;
    UPD_STATUS = 8'hFF;
    UPD_SUPPORT = 8'hFB;
    UPD_INT_PART = 32'h00009C40;
    UPD_FRAC_MILLI = 16'hFE70;
    UPD_FLOAT = 32'h449A5CCD;
    UPD_SCALED = 32'h00BC614E;
    UPD_DECIMALS = 16'h0003;
    UPD_STATE_A = 16'h1234;
    UPD_WIN_WORDS = 48'h111122223333;
    rst(1'b1);
    base = 160;
    upd(8, 1'b1, 1'b1);
    rd(161, 1, 8'h07);
    rd(162, 4, 32'h00BC614E);
    rd(166, 2, 16'h0003);
    rd(168, 2, 16'h1234);
    rd(170, 2, 16'h0010);
    rd(320, 1, 8'h00);
    $display("test long inbound done");
    wr(162, 8'h9C);
    wr(163, 8'h5F);
    cmd(CMD_WINDOW, 1);
    `CHK(last_origin, 16'h9C5F)
    rd(160, 1, CMD_WINDOW);
    rd(172, 4, 32'h9C5F1111);
    rd(176, 4, 32'h22223333);
    cmd(CMD_WINDOW, 1);
    cmd(CMD_NONE, 1);
    $display("test window done");
    upd(8, 1'b1, 1'b0);
    rd(170, 2, 16'h0010);
    cmd(CMD_PFCLR, 2);
    upd(8, 1'b1, 1'b0);
    rd(170, 2, 16'h0000);
    wr(161, 8'h09);
    cmd(CMD_WRITE, 2);
    rd(160, 1, ACK_REFUSED);
    cmd(CMD_NONE, 2);
    wr(161, 8'h02);
    wr(164, 8'h42);
    wr(165, 8'hF7);
    code_set <= 8'hFB;
    cmd(CMD_WRITE, 3);
    `CHK(last_cmd, CMD_WRITE)
    `CHK(last_count, 8'h02)
    `CHK(last_words[127:112], 16'h42F7)
    `CHK(last_slot, 4'h8)
    rd(160, 1, 8'hFB);
    upd(8, 1'b0, 1'b0);
    rd(161, 1, FAULT_COMM);
    $display("test long commands done");
    rst(1'b0);
    base = 48;
    code_set <= 8'h00;
    upd(8, 1'b1, 1'b1);
    rd(48, 1, 8'hFB);
    rd(49, 1, 8'h07);
    rd(50, 4, 32'h7FFFFE70);
    WEIGHT_FORMAT_FLOAT <= 1'b1;
    upd(8, 1'b1, 1'b0);
    rd(50, 4, 32'h449A5CCD);
    rd(48, 1, 8'hFB);
    cmd(CMD_PFCLR, 1);
    `CHK(last_slot, 4'h8)
    upd(8, 1'b1, 1'b0);
    rd(48, 1, 8'hDB);
    $display("test short map done");
    wrap_up();
  end
endmodule // gateway_slot_memory_tb
